// [bank_table.sv]
// Purpose: open/closed state and open row of every bank
// Assumes: decoded command valid only when cmd_valid is high
// Notes:   auto close takes effect on the access edge itself
`timescale 1ns/1ns
module bank_table
  import cmd_input_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  cmd_valid,
  input  decoded_s                   dec,
  output logic [BANKS-1:0]           open_reg,
  output logic [BANKS-1:0][ROW_W-1:0] row_reg
);

  logic [BANKS-1:0]            open_next;
  logic [BANKS-1:0][ROW_W-1:0] row_next;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++)
    begin : g_bank
      logic hit;
      assign hit = (dec.bank == BANK_IDX_W'(b));
      always_comb
      begin
        open_next[b] = open_reg[b];
        row_next[b]  = row_reg[b];
        if (cmd_valid) // [RQ19]
        begin
          unique case (dec.cmd)
            CMD_ACTIVATE:
              if (hit)
              begin
                open_next[b] = 1'b1;
                row_next[b]  = dec.row; // [RQ13]
              end
            CMD_READ, CMD_WRITE:
              if (hit && dec.auto_close)
                open_next[b] = 1'b0; // [RQ21]
            CMD_PRECHARGE:
              if (hit || dec.all_banks)
                open_next[b] = 1'b0; // [RQ21]
            default: ;
          endcase
        end
      end
      always_ff @(posedge clk)
      begin
        if (rst)
        begin
          open_reg[b] <= 1'b0;
          row_reg[b]  <= '0;
        end
        else if (ce)
        begin
          open_reg[b] <= open_next[b];
          row_reg[b]  <= row_next[b];
        end
      end
    end
  endgenerate

endmodule

// [cmd_decoder.sv]
// Purpose: combinational command decode of one sampled edge
// Assumes: pins already registered on the rising clock
// Notes:   pure logic, no state
`timescale 1ns/1ns
module cmd_decoder
  import cmd_input_pkg::*;
(
  input  cmd_pins_s pins,
  input  config_s   cfg,
  output decoded_s  dec
);

  always_comb
  begin
    dec            = '0;
    dec.cmd        = CMD_NOP;
    dec.bank       = bank_index(pins.group_select, pins.bank_select_bits); // [RQ14] [RQ23]
    dec.col        = pins.addr[COL_W-1:0];
    dec.auto_close = pins.addr[AUTO_CLOSE_POS]; // [RQ21]
    dec.all_banks  = pins.addr[AUTO_CLOSE_POS]; // [RQ21]
    dec.row        = {pins.row_strobe, pins.column_strobe, pins.write_strobe,
                      pins.addr[13:0]}; // [RQ13]
    unique case (cfg.burst_mode) // [RQ16]
      BURST_FIXED4: dec.burst_len = BURST_LEN4;
      BURST_OTF:    dec.burst_len = pins.addr[CHOP_POS] ? BURST_LEN8 : BURST_LEN4; // [RQ22]
      default:      dec.burst_len = BURST_LEN8;
    endcase
    if (pins.select_n)
      dec.cmd = CMD_DESELECT; // [RQ8] [RQ9]
    else if (!pins.activate_n)
      dec.cmd = CMD_ACTIVATE; // [RQ12]
    else
    begin
      unique case ({pins.row_strobe, pins.column_strobe, pins.write_strobe}) // [RQ20]
        3'h0: dec.cmd = CMD_MODE_SET;
        3'h1: dec.cmd = CMD_REFRESH;
        3'h2: dec.cmd = CMD_PRECHARGE;
        3'h3: dec.cmd = CMD_RESERVED;
        3'h4: dec.cmd = CMD_WRITE;
        3'h5: dec.cmd = CMD_READ;
        3'h6: dec.cmd = CMD_ZQ;
        3'h7: dec.cmd = CMD_NOP;
      endcase
    end
  end

endmodule

// [cmd_input_pkg.sv]
// Purpose: shared constants and types for the command input front end
// Assumes: single clock, synchronous active-high reset
// Notes:   widths follow a x16 part with eight banks
package cmd_input_pkg;

  localparam int ROW_W        = 17;
  localparam int COL_W        = 10;
  localparam int GROUP_W      = 1;
  localparam int BANK_W       = 2;
  localparam int NUM_GROUPS   = 2;
  localparam int BANKS_PER_GR = 4;
  localparam int NUM_BANKS    = NUM_GROUPS * BANKS_PER_GR;
  localparam int BANK_IDX_W   = 3;
  localparam int ADDR_W       = 17;

  localparam int AUTO_CLOSE_POS = 10;
  localparam int CHOP_POS       = 12;

  // burst mode field encoding
  localparam logic [1:0] BURST_FIXED8  = 2'h0;
  localparam logic [1:0] BURST_OTF     = 2'h1;
  localparam logic [1:0] BURST_FIXED4  = 2'h2;

  // added latency field encoding
  localparam logic [1:0] AL_ZERO      = 2'h0;
  localparam logic [1:0] AL_CL_MINUS1 = 2'h1;
  localparam logic [1:0] AL_CL_MINUS2 = 2'h2;

  localparam logic [4:0] LAT_W_MAX    = 5'h1F;
  localparam logic [3:0] BURST_LEN8   = 4'h8;
  localparam logic [3:0] BURST_LEN4   = 4'h4;

  // refresh interval figures, kept for the controller side
  localparam int    REFRESH_COUNT   = 8192;
  localparam real   REFI_NORMAL_US  = 7.8;
  localparam real   REFI_HOT_US     = 3.9;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_REFRESH, CMD_MODE_SET, CMD_ZQ, CMD_RESERVED
  } cmd_e;

  typedef struct packed {
    logic              select_n;
    logic              activate_n;
    logic              row_strobe;
    logic              column_strobe;
    logic              write_strobe;
    logic [GROUP_W-1:0] group_select;
    logic [BANK_W-1:0]  bank_select_bits;
    logic [ADDR_W-1:0]  addr;
  } cmd_pins_s;

  typedef struct packed {
    logic [1:0] burst_mode;
    logic       interleave;
    logic [1:0] added_latency;
    logic [4:0] read_latency;
    logic       nominal_termination_on;
  } config_s;

  typedef struct packed {
    cmd_e                  cmd;
    logic [BANK_IDX_W-1:0] bank;
    logic [ROW_W-1:0]      row;
    logic [COL_W-1:0]      col;
    logic                  auto_close;
    logic                  all_banks;
    logic [3:0]            burst_len;
  } decoded_s;

  // bank index from group and bank pins, used only in the decoder
  function automatic logic [BANK_IDX_W-1:0] bank_index(
    input logic [GROUP_W-1:0] grp,
    input logic [BANK_W-1:0]  bnk);
    bank_index = {grp, bnk};
  endfunction

endpackage

// [cmd_input_top.sv]
// Purpose: command and control input front end of a x16 DDR DRAM
// Assumes: pins synchronous to CLK_SYS; CLK_SYS rising = true clock rise
// Notes:   data path, strobes, training and parity are not modelled
// Notes on behaviour
// [RQ1] sample control and address on clock rise
// [RQ2] gate high enables clocks, buffers, drivers
// [RQ3] gate low: idle -> power-down/self-refresh, else active
// [RQ4] gate seen without clock when leaving self-refresh
// [RQ5] controller keeps gate high during accesses
// [RQ6] power-down keeps only clock, termination, gate buffers
// [RQ7] self-refresh keeps only gate buffer
// [RQ8] deasserted select masks the command
// [RQ9] select is part of command code
// [RQ10] termination pin high enables nominal termination
// [RQ11] termination disabled in config ignores the pin
// [RQ12] activate input low with select decodes activate
// [RQ13] shared pins are upper row bits on activate
// [RQ14] eight banks, two groups of four
// [RQ15] added latency zero, latency-1, or latency-2
// [RQ16] fixed eight, fixed four, or on-the-fly burst
// [RQ17] sequential or interleaved burst ordering
// [RQ18] controller refreshes 8192 per 64 ms
// [RQ19] deselected edge changes nothing
// [RQ20] activate high: shared pins are command bits
// [RQ21] bit ten: auto close, or all-bank precharge
// [RQ22] on-the-fly: bit twelve low chops to four
// [RQ23] group and bank pins select target bank
`timescale 1ns/1ns
module cmd_input_top
  import cmd_input_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
)
(
  input  wire logic                   CLK_SYS,
  input  wire logic                   RST,
  input  wire logic                   CE,
  input  wire logic                   CLOCK_GATE,
  input  wire logic                   SELECT_N,
  input  wire logic                   ACTIVATE_STROBE_N,
  input  wire logic                   ROW_STROBE_SHARED_PIN,
  input  wire logic                   COLUMN_STROBE_SHARED_PIN,
  input  wire logic                   WRITE_STROBE_SHARED_PIN,
  input  wire logic [GROUP_W-1:0]     GROUP_SELECT,
  input  wire logic [BANK_W-1:0]      BANK_SELECT_BITS,
  input  wire logic [ADDR_W-1:0]      ADDR,
  input  wire logic                   TERMINATION_ENABLE_PIN,
  input  wire logic [1:0]             CFG_BURST_MODE,
  input  wire logic                   CFG_INTERLEAVE,
  input  wire logic [1:0]             CFG_ADDED_LATENCY,
  input  wire logic [4:0]             CFG_READ_LATENCY,
  input  wire logic                   CFG_NOMINAL_TERMINATION,
  output logic                        CMD_VALID,
  output cmd_e                        CMD_CODE,
  output logic [BANK_IDX_W-1:0]       CMD_BANK,
  output logic [ROW_W-1:0]            CMD_ROW,
  output logic [COL_W-1:0]            CMD_COL,
  output logic                        CMD_AUTO_CLOSE,
  output logic                        CMD_ALL_BANKS,
  output logic [3:0]                  CMD_BURST_LEN,
  output logic                        CMD_INTERLEAVE,
  output logic [4:0]                  EFFECTIVE_ADDED_LATENCY,
  output logic                        INTERNAL_CLOCK_ON,
  output logic                        CMD_BUFFERS_ON,
  output logic                        CLOCK_BUFFERS_ON,
  output logic                        TERMINATION_BUFFER_ON,
  output logic                        OUTPUT_DRIVERS_ON,
  output logic                        TERMINATION_ON,
  output logic                        PRECHARGE_POWER_DOWN,
  output logic                        ACTIVE_POWER_DOWN,
  output logic                        SELF_REFRESH,
  output logic [BANKS-1:0]            BANK_OPEN,
  output logic                        ACCESS_GATE_FAULT
);

  typedef enum logic [1:0] {PWR_ACTIVE, PWR_PRE_DOWN, PWR_ACT_DOWN, PWR_SELF_REF} pwr_e;

  // power state
  pwr_e pwr_reg;
  pwr_e pwr_next;

  // sampled pins
  cmd_pins_s pins_reg;
  cmd_pins_s pins_next;
  logic      gate_reg;
  logic      term_pin_reg;

  always_comb
  begin
    pins_next.select_n         = SELECT_N;
    pins_next.activate_n       = ACTIVATE_STROBE_N;
    pins_next.row_strobe       = ROW_STROBE_SHARED_PIN;
    pins_next.column_strobe    = COLUMN_STROBE_SHARED_PIN;
    pins_next.write_strobe     = WRITE_STROBE_SHARED_PIN;
    pins_next.group_select     = GROUP_SELECT;
    pins_next.bank_select_bits = BANK_SELECT_BITS;
    pins_next.addr             = ADDR;
  end

  logic cmd_buf_on;
  logic clk_buf_on;
  logic term_buf_on;

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      pins_reg     <= '{select_n: 1'b1, default: '0};
      gate_reg     <= 1'b0;
      term_pin_reg <= 1'b0;
    end
    else if (CE)
    begin
      // closed command buffers look like a deselect
      pins_reg     <= cmd_buf_on ? pins_next : '{select_n: 1'b1, default: '0}; // [RQ1] [RQ6]
      gate_reg     <= CLOCK_GATE;
      term_pin_reg <= term_buf_on ? TERMINATION_ENABLE_PIN : 1'b0; // [RQ6] [RQ7]
    end
  end

  // configuration, only taken while the device is active
  config_s cfg_reg;
  config_s cfg_next;

  decoded_s dec;

  cmd_decoder u_dec (
    .pins (pins_reg),
    .cfg  (cfg_reg),
    .dec  (dec)
  );

  logic cmd_ok;
  assign cmd_ok = (dec.cmd != CMD_DESELECT) && (dec.cmd != CMD_NOP)
                  && (dec.cmd != CMD_RESERVED) && gate_reg; // [RQ8] [RQ19]

  logic [BANKS-1:0]            open_reg;
  // open rows stay inside the bank table; nothing here reads them

  bank_table #(.BANKS(BANKS)) u_banks (
    .clk       (CLK_SYS),
    .rst       (RST),
    .ce        (CE),
    .cmd_valid (cmd_ok),
    .dec       (dec),
    .open_reg  (open_reg),
    .row_reg   ()
  );

  always_comb
  begin
    cfg_next = cfg_reg;
    if (pwr_reg == PWR_ACTIVE)
    begin
      cfg_next.burst_mode             = CFG_BURST_MODE; // [RQ16]
      cfg_next.interleave             = CFG_INTERLEAVE; // [RQ17]
      cfg_next.added_latency          = CFG_ADDED_LATENCY; // [RQ15]
      cfg_next.read_latency           = CFG_READ_LATENCY;
      cfg_next.nominal_termination_on = CFG_NOMINAL_TERMINATION;
    end
  end


  always_comb
  begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_ACTIVE:
        if (!gate_reg)
        begin
          if (|open_reg)
            pwr_next = PWR_ACT_DOWN; // [RQ3]
          else if (dec.cmd == CMD_REFRESH)
            pwr_next = PWR_SELF_REF; // [RQ3]
          else
            pwr_next = PWR_PRE_DOWN; // [RQ3]
        end
      PWR_PRE_DOWN, PWR_ACT_DOWN:
        if (gate_reg)
          pwr_next = PWR_ACTIVE; // [RQ2]
      PWR_SELF_REF:
        // raw pin, not the sampled copy: exit needs no registered edge
        if (CLOCK_GATE)
          pwr_next = PWR_ACTIVE; // [RQ4]
    endcase
  end

  assign cmd_buf_on  = (pwr_reg == PWR_ACTIVE); // [RQ6] [RQ7]
  assign clk_buf_on  = (pwr_reg != PWR_SELF_REF); // [RQ6] [RQ7]
  assign term_buf_on = clk_buf_on; // [RQ6] [RQ7]

  // registered outputs
  logic out_valid_next;
  logic term_on_next;
  logic [4:0] eff_al_next;

  always_comb
  begin
    out_valid_next = cmd_ok && (pwr_reg == PWR_ACTIVE);
    term_on_next   = term_pin_reg && cfg_reg.nominal_termination_on
                     && clk_buf_on; // [RQ10] [RQ11]
    unique case (cfg_reg.added_latency) // [RQ15]
      AL_CL_MINUS1: eff_al_next = cfg_reg.read_latency - 5'h01;
      AL_CL_MINUS2: eff_al_next = cfg_reg.read_latency - 5'h02;
      default:      eff_al_next = 5'h00;
    endcase
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (RST)
    begin
      cfg_reg                 <= '{burst_mode: BURST_FIXED8, default: '0};
      pwr_reg                 <= PWR_ACTIVE;
      CMD_VALID               <= 1'b0;
      CMD_CODE                <= CMD_NOP;
      CMD_BANK                <= '0;
      CMD_ROW                 <= '0;
      CMD_COL                 <= '0;
      CMD_AUTO_CLOSE          <= 1'b0;
      CMD_ALL_BANKS           <= 1'b0;
      CMD_BURST_LEN           <= BURST_LEN8;
      CMD_INTERLEAVE          <= 1'b0;
      EFFECTIVE_ADDED_LATENCY <= 5'h00;
      INTERNAL_CLOCK_ON       <= 1'b0;
      CMD_BUFFERS_ON          <= 1'b0;
      CLOCK_BUFFERS_ON        <= 1'b0;
      TERMINATION_BUFFER_ON   <= 1'b0;
      OUTPUT_DRIVERS_ON       <= 1'b0;
      TERMINATION_ON          <= 1'b0;
      PRECHARGE_POWER_DOWN    <= 1'b0;
      ACTIVE_POWER_DOWN       <= 1'b0;
      SELF_REFRESH            <= 1'b0;
      BANK_OPEN               <= '0;
      ACCESS_GATE_FAULT       <= 1'b0;
    end
    else if (CE)
    begin
      cfg_reg                 <= cfg_next;
      pwr_reg                 <= pwr_next;
      CMD_VALID               <= out_valid_next; // [RQ8]
      CMD_CODE                <= dec.cmd;
      CMD_BANK                <= dec.bank; // [RQ23]
      CMD_ROW                 <= dec.row; // [RQ13]
      CMD_COL                 <= dec.col;
      CMD_AUTO_CLOSE          <= dec.auto_close;
      CMD_ALL_BANKS           <= dec.all_banks;
      CMD_BURST_LEN           <= dec.burst_len;
      CMD_INTERLEAVE          <= cfg_reg.interleave; // [RQ17]
      EFFECTIVE_ADDED_LATENCY <= eff_al_next;
      INTERNAL_CLOCK_ON       <= (pwr_next == PWR_ACTIVE); // [RQ2]
      CMD_BUFFERS_ON          <= (pwr_next == PWR_ACTIVE);
      CLOCK_BUFFERS_ON        <= (pwr_next != PWR_SELF_REF);
      TERMINATION_BUFFER_ON   <= (pwr_next != PWR_SELF_REF);
      OUTPUT_DRIVERS_ON       <= (pwr_next == PWR_ACTIVE); // [RQ2]
      TERMINATION_ON          <= term_on_next;
      PRECHARGE_POWER_DOWN    <= (pwr_next == PWR_PRE_DOWN);
      ACTIVE_POWER_DOWN       <= (pwr_next == PWR_ACT_DOWN);
      SELF_REFRESH            <= (pwr_next == PWR_SELF_REF);
      BANK_OPEN               <= open_reg;
      // flags a gate drop on the edge of an access
      ACCESS_GATE_FAULT       <= !gate_reg && !dec.cmd[3]
                                 && (dec.cmd == CMD_READ || dec.cmd == CMD_WRITE); // [RQ5]
    end
  end

  chk_deselect_quiet: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ8]
    CE && pins_reg.select_n |=> !CMD_VALID)
    else $error("deselected edge produced a command");

  chk_act_opens_bank: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ12]
    CE && cmd_ok && dec.cmd == CMD_ACTIVATE ##1 CE |-> open_reg[$past(dec.bank)])
    else $error("activate did not open the bank");

  chk_term_ignored: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ11]
    CE && !cfg_reg.nominal_termination_on |=> !TERMINATION_ON)
    else $error("termination on while disabled");

  chk_selfref_bufs: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ7]
    SELF_REFRESH |-> !CLOCK_BUFFERS_ON && !CMD_BUFFERS_ON)
    else $error("buffers on in self refresh");

  chk_powerdown_kind: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ3]
    CE && pwr_reg == PWR_ACTIVE && !gate_reg && (|open_reg) |=> ACTIVE_POWER_DOWN)
    else $error("open bank did not give active power down");

  chk_selfref_exit: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ4]
    CE && pwr_reg == PWR_SELF_REF && CLOCK_GATE |=> pwr_reg == PWR_ACTIVE)
    else $error("self refresh exit missed");

  chk_chop_four: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ22]
    CE && cfg_reg.burst_mode == BURST_OTF && !pins_reg.addr[CHOP_POS]
    |=> CMD_BURST_LEN == BURST_LEN4)
    else $error("burst not chopped");

  chk_precharge_all: assert property (@(posedge CLK_SYS) disable iff (RST) // [RQ21]
    CE && cmd_ok && dec.cmd == CMD_PRECHARGE && dec.all_banks ##1 CE |-> open_reg == '0)
    else $error("all-bank precharge left a bank open");

endmodule

// [host_ctrl_model.sv]
// Purpose: behavioural memory controller driving the command front end
// Assumes: pins change only on the falling clock edge
// Notes:   deselected pins carry inverted stale values, a clean idle only before the first command
`timescale 1ns/1ns
module host_ctrl_model
  import cmd_input_pkg::*;
(
  input  wire logic clk,
  output cmd_pins_s  pins,
  output logic       clock_gate,
  output logic       term_pin
);

  initial
  begin
    pins          = '0;
    pins.select_n = 1'b1;
    clock_gate    = 1'b1;
    term_pin      = 1'b0;
  end

  // stale bits flip so a masked edge cannot pass by replaying the last command
  task automatic release_pins();
    pins          = ~pins;
    pins.select_n = 1'b1;
  endtask

  task automatic drive(input logic sel_n, input logic act_n, input logic [2:0] code,
                       input logic [2:0] bank, input logic [ADDR_W-1:0] a);
    pins.select_n   = sel_n;
    pins.activate_n = act_n;
    {pins.row_strobe, pins.column_strobe, pins.write_strobe} = code;
    {pins.group_select, pins.bank_select_bits}               = bank;
    pins.addr       = a;
  endtask

  // one command held for exactly one rising edge
  task automatic issue(input logic sel_n, input logic act_n, input logic [2:0] code,
                       input logic [2:0] bank, input logic [ADDR_W-1:0] a);
    @(negedge clk);
    drive(sel_n, act_n, code, bank, a);
    @(negedge clk);
    release_pins();
  endtask

  // gate moves on a falling edge; t_power also drops it on a read edge to raise the fault
  task automatic set_gate(input logic v);
    @(negedge clk);
    clock_gate = v;
  endtask

  task automatic set_term(input logic v);
    @(negedge clk);
    term_pin = v;
  endtask

  // refresh and gate low sampled on one edge, so the idle device sleeps
  task automatic enter_self_refresh();
    @(negedge clk);
    drive(1'b0, 1'b1, 3'b001, 3'h0, '0);
    clock_gate = 1'b0;
    @(negedge clk);
    release_pins();
  endtask

endmodule

// [tb_dram_command_input_control.sv]
// Purpose: self-checking bench for the command input front end
// Assumes: command answer one edge after the pins are sampled
// Notes:   CE dropped once, in the latency scenario
`timescale 1ns/1ns
module tb_dram_command_input_control
  import cmd_input_pkg::*;
;
  localparam logic [4:0] RD_LAT      = 5'h0B;
  localparam int         CYCLE_LIMIT = 3000;

  logic                  CLK_SYS = 1'b0;
  logic                  RST = 1'b1;
  logic                  CE;
  logic [1:0]            CFG_BURST_MODE = BURST_FIXED8;
  logic                  CFG_INTERLEAVE = 1'b0;
  logic [1:0]            CFG_ADDED_LATENCY = AL_ZERO;
  logic [4:0]            CFG_READ_LATENCY;
  logic                  CFG_NOMINAL_TERMINATION = 1'b1;
  cmd_pins_s             pins;
  logic                  clock_gate;
  logic                  term_pin;
  logic                  CMD_VALID, CMD_AUTO_CLOSE, CMD_ALL_BANKS, CMD_INTERLEAVE;
  cmd_e                  CMD_CODE;
  logic [BANK_IDX_W-1:0] CMD_BANK;
  logic [ROW_W-1:0]      CMD_ROW;
  logic [COL_W-1:0]      CMD_COL;
  logic [3:0]            CMD_BURST_LEN;
  logic [4:0]            EFFECTIVE_ADDED_LATENCY;
  logic                  INTERNAL_CLOCK_ON, CMD_BUFFERS_ON, CLOCK_BUFFERS_ON;
  logic                  TERMINATION_BUFFER_ON, OUTPUT_DRIVERS_ON, TERMINATION_ON;
  logic                  PRECHARGE_POWER_DOWN, ACTIVE_POWER_DOWN, SELF_REFRESH, ACCESS_GATE_FAULT;
  logic [NUM_BANKS-1:0]  BANK_OPEN;
  int                    n_errors = 0;
  int                    num_checks = 0;
  int                    cycles = 0;

  logic [2:0] cmd_bits [6] = '{3'b101, 3'b100, 3'b000, 3'b110, 3'b111, 3'b011};
  cmd_e       cmd_exp  [6] = '{CMD_READ, CMD_WRITE, CMD_MODE_SET, CMD_ZQ, CMD_NOP, CMD_NOP};
  logic [1:0] bmode    [4] = '{BURST_FIXED8, BURST_FIXED4, BURST_OTF, BURST_OTF};
  logic       bchop    [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  logic [3:0] blen     [4] = '{BURST_LEN8, BURST_LEN4, BURST_LEN8, BURST_LEN4};
  logic [1:0] al_code  [3] = '{AL_ZERO, AL_CL_MINUS1, AL_CL_MINUS2};
  logic [4:0] al_exp   [3] = '{5'h00, RD_LAT - 5'h01, RD_LAT - 5'h02};

  always #20 CLK_SYS = ~CLK_SYS;

  host_ctrl_model u_host_ctrl_model (
    .clk        (CLK_SYS),
    .pins       (pins),
    .clock_gate (clock_gate),
    .term_pin   (term_pin)
  );

  cmd_input_top #(.BANKS(NUM_BANKS)) u_cmd_input_top (
    .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .CLOCK_GATE(clock_gate),
    .SELECT_N(pins.select_n), .ACTIVATE_STROBE_N(pins.activate_n),
    .ROW_STROBE_SHARED_PIN(pins.row_strobe), .COLUMN_STROBE_SHARED_PIN(pins.column_strobe),
    .WRITE_STROBE_SHARED_PIN(pins.write_strobe), .GROUP_SELECT(pins.group_select),
    .BANK_SELECT_BITS(pins.bank_select_bits), .ADDR(pins.addr),
    .TERMINATION_ENABLE_PIN(term_pin), .CFG_BURST_MODE(CFG_BURST_MODE),
    .CFG_INTERLEAVE(CFG_INTERLEAVE), .CFG_ADDED_LATENCY(CFG_ADDED_LATENCY),
    .CFG_READ_LATENCY(CFG_READ_LATENCY), .CFG_NOMINAL_TERMINATION(CFG_NOMINAL_TERMINATION),
    .CMD_VALID(CMD_VALID), .CMD_CODE(CMD_CODE), .CMD_BANK(CMD_BANK), .CMD_ROW(CMD_ROW),
    .CMD_COL(CMD_COL), .CMD_AUTO_CLOSE(CMD_AUTO_CLOSE), .CMD_ALL_BANKS(CMD_ALL_BANKS),
    .CMD_BURST_LEN(CMD_BURST_LEN), .CMD_INTERLEAVE(CMD_INTERLEAVE),
    .EFFECTIVE_ADDED_LATENCY(EFFECTIVE_ADDED_LATENCY), .INTERNAL_CLOCK_ON(INTERNAL_CLOCK_ON),
    .CMD_BUFFERS_ON(CMD_BUFFERS_ON), .CLOCK_BUFFERS_ON(CLOCK_BUFFERS_ON),
    .TERMINATION_BUFFER_ON(TERMINATION_BUFFER_ON), .OUTPUT_DRIVERS_ON(OUTPUT_DRIVERS_ON),
    .TERMINATION_ON(TERMINATION_ON), .PRECHARGE_POWER_DOWN(PRECHARGE_POWER_DOWN),
    .ACTIVE_POWER_DOWN(ACTIVE_POWER_DOWN), .SELF_REFRESH(SELF_REFRESH),
    .BANK_OPEN(BANK_OPEN), .ACCESS_GATE_FAULT(ACCESS_GATE_FAULT)
  );

  task automatic results();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (cycles == CYCLE_LIMIT)
    begin
      n_errors++;
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge CLK_SYS);
    #1;
  endtask

  // CMD_NOP as expectation means the edge must be refused
  task automatic cmd(input logic sel_n, input logic act_n, input logic [2:0] code,
                     input logic [2:0] bank, input logic [ADDR_W-1:0] a, input cmd_e exp);
    u_host_ctrl_model.issue(sel_n, act_n, code, bank, a);
    settle(1);
    check(CMD_VALID, exp != CMD_NOP, "valid");
    if (exp != CMD_NOP)
    begin
      check(CMD_CODE, exp, "code");
      check(CMD_BANK, bank, "bank");
    end
  endtask

  task automatic t_reset();
    check(CMD_CODE, CMD_NOP, "reset code");
    check(CMD_BURST_LEN, BURST_LEN8, "reset burst");
    check(BANK_OPEN, 8'h00, "reset banks");
    settle(2);
    check({INTERNAL_CLOCK_ON, CMD_BUFFERS_ON, OUTPUT_DRIVERS_ON}, 3'h7, "run");
  endtask

  task automatic t_activate();
    cmd(1'b0, 1'b0, 3'b101, 3'h5, 17'h02A5, CMD_ACTIVATE);
    check(CMD_ROW, {3'b101, 14'h02A5}, "row");
    settle(1);
    check(CMD_VALID, 1'b0, "pulse");
    settle(1);
    check(BANK_OPEN, 8'h20, "open");
  endtask

  task automatic t_deselect();
    cmd(1'b1, 1'b0, 3'b000, 3'h2, 17'h1FFFF, CMD_NOP);
    cmd(1'b1, 1'b1, 3'b010, 3'h5, 17'h00400, CMD_NOP);
    settle(2);
    check(BANK_OPEN, 8'h20, "masked");
  endtask

  task automatic t_commands();
    for (int i = 0; i < 6; i++)
      cmd(1'b0, 1'b1, cmd_bits[i], 3'h5, 17'h00123, cmd_exp[i]);
    cmd(1'b0, 1'b1, 3'b101, 3'h5, 17'h00523, CMD_READ);
    check(CMD_COL, 10'h123, "column");
    check(CMD_AUTO_CLOSE, 1'b1, "auto close");
    settle(2);
    check(BANK_OPEN, 8'h00, "closed");
  endtask

  task automatic t_burst();
    cmd(1'b0, 1'b0, 3'b000, 3'h1, 17'h00000, CMD_ACTIVATE);
    for (int i = 0; i < 4; i++)
    begin
      @(negedge CLK_SYS);
      CFG_BURST_MODE = bmode[i];
      CFG_INTERLEAVE = i[0];
      cmd(1'b0, 1'b1, 3'b101, 3'h1, {4'h0, bchop[i], 12'h000}, CMD_READ);
      check(CMD_BURST_LEN, blen[i], "burst");
      check(CMD_INTERLEAVE, i[0], "order");
    end
  endtask

  task automatic t_latency();
    for (int i = 0; i < 3; i++)
    begin
      @(negedge CLK_SYS);
      CFG_ADDED_LATENCY = al_code[i];
      settle(3);
      check(EFFECTIVE_ADDED_LATENCY, al_exp[i], "added latency");
    end
    @(negedge CLK_SYS);
    CE = 1'b0;
    CFG_READ_LATENCY = 5'h10;
    settle(3);
    check(EFFECTIVE_ADDED_LATENCY, al_exp[2], "frozen");
    @(negedge CLK_SYS);
    CE = 1'b1;
    settle(3);
    check(EFFECTIVE_ADDED_LATENCY, 5'h0E, "latency");
  endtask

  task automatic t_termination();
    u_host_ctrl_model.set_term(1'b1);
    settle(3);
    check(TERMINATION_ON, 1'b1, "term on");
    @(negedge CLK_SYS);
    CFG_NOMINAL_TERMINATION = 1'b0;
    settle(3);
    check(TERMINATION_ON, 1'b0, "term ignored");
    @(negedge CLK_SYS);
    CFG_NOMINAL_TERMINATION = 1'b1;
    u_host_ctrl_model.set_term(1'b0);
    settle(3);
    check(TERMINATION_ON, 1'b0, "term off");
  endtask

  task automatic t_power();
    cmd(1'b0, 1'b1, 3'b010, 3'h0, 17'h00400, CMD_PRECHARGE);
    check(CMD_ALL_BANKS, 1'b1, "all banks");
    u_host_ctrl_model.set_gate(1'b0);
    settle(3);
    check({PRECHARGE_POWER_DOWN, ACTIVE_POWER_DOWN}, 2'b10, "idle down");
    check({INTERNAL_CLOCK_ON, CMD_BUFFERS_ON, OUTPUT_DRIVERS_ON}, 3'h0, "off");
    check({CLOCK_BUFFERS_ON, TERMINATION_BUFFER_ON}, 2'b11, "kept");
    cmd(1'b0, 1'b0, 3'b000, 3'h3, 17'h00000, CMD_NOP);
    u_host_ctrl_model.set_gate(1'b1);
    settle(3);
    check({PRECHARGE_POWER_DOWN, CMD_BUFFERS_ON}, 2'b01, "wake");
    fork
      u_host_ctrl_model.set_gate(1'b0);
      u_host_ctrl_model.issue(1'b0, 1'b1, 3'b101, 3'h3, 17'h00000);
    join
    settle(1);
    check({ACCESS_GATE_FAULT, CMD_VALID}, 2'b10, "gate fault");
    u_host_ctrl_model.set_gate(1'b1);
    settle(3);
    cmd(1'b0, 1'b0, 3'b000, 3'h3, 17'h00000, CMD_ACTIVATE);
    settle(1);
    u_host_ctrl_model.set_gate(1'b0);
    settle(3);
    check({PRECHARGE_POWER_DOWN, ACTIVE_POWER_DOWN}, 2'b01, "active down");
    u_host_ctrl_model.set_gate(1'b1);
    settle(3);
    cmd(1'b0, 1'b1, 3'b010, 3'h0, 17'h00400, CMD_PRECHARGE);
    settle(2);
    check(BANK_OPEN, 8'h00, "all closed");
  endtask

  task automatic t_self_refresh();
    u_host_ctrl_model.enter_self_refresh();
    settle(3);
    check({SELF_REFRESH, CLOCK_BUFFERS_ON, TERMINATION_BUFFER_ON}, 3'h4, "sleep");
    check(CMD_BUFFERS_ON, 1'b0, "sleep cmd");
    u_host_ctrl_model.set_gate(1'b1);
    settle(2);
    check({SELF_REFRESH, CMD_BUFFERS_ON}, 2'b01, "exit");
  endtask

  initial
  begin
    CE = 1'b1;
    CFG_READ_LATENCY = RD_LAT;
    repeat (6) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RST = 1'b0;
    t_reset();
    t_activate();
    t_deselect();
    t_commands();
    t_burst();
    t_latency();
    t_termination();
    t_power();
    t_self_refresh();
    results();
  end

endmodule
